//--- core/mpg_pkg.sv
// Package for the multi-purpose pin and output gating block.
// Assumes APB register access with one 32-bit word per register index.
package mpg_pkg;

  localparam int unsigned NUM_PLL  = 3;
  localparam int unsigned NUM_BANK = 6;
  localparam int unsigned NUM_IN   = 6;
  localparam int unsigned NUM_CFG  = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_MODE      = 6'h04;
  localparam logic [5:0] IDX_IN_EN     = 6'h06;
  localparam logic [5:0] IDX_SHUT      = 6'h1c;
  localparam logic [5:0] IDX_SUSP      = 6'h1d;
  localparam logic [5:0] IDX_PLL_PAUSE = 6'h1e;
  localparam logic [5:0] IDX_DIV_SEL   = 6'h20;
  localparam logic [5:0] IDX_REF_CTL   = 6'h21;
  localparam logic [5:0] IDX_STYLE     = 6'h22;
  localparam logic [5:0] IDX_SRC       = 6'h23;
  localparam logic [5:0] IDX_STATUS    = 6'h24;

  // Field positions inside the shutdown control word.
  localparam int unsigned SHUT_POL_BIT  = 0;
  localparam int unsigned SHUT_ROLE_BIT = 1;
  localparam int unsigned SHUT_MASK_LSB = 8;

  // Field positions inside the status word.
  localparam int unsigned STAT_MODE_LSB  = 6;
  localparam int unsigned STAT_TRI_LSB   = 8;
  localparam int unsigned STAT_PD_LSB    = 14;
  localparam int unsigned STAT_RELCK_LSB = 17;

  // Reset values.
  localparam logic [5:0]  IN_EN_RST = 6'h3f;
  localparam logic [11:0] SRC_RST   = 12'h000;

  // Codes.
  localparam logic [1:0] STYLE_KEEP = 2'h2;
  localparam logic [1:0] SRC_REF    = 2'h3;
  localparam logic [1:0] LATCH_WAIT = 2'h2;

  typedef enum logic [1:0] {
    MPG_MODE_MAN_ALL  = 2'b00,
    MPG_MODE_MAN_ONE  = 2'b01,
    MPG_MODE_TWO_WIRE = 2'b10,
    MPG_MODE_JTAG     = 2'b11
  } mpg_mode_t;

  typedef struct packed {
    logic       ser_hi;
    logic       ser_lo;
    logic       goe;
    logic [5:0] in;
  } mpg_pins_t;

  typedef struct packed {
    logic [1:0] pll2;
    logic [1:0] pll1;
    logic [1:0] pll0;
  } mpg_cfg_sel_t;

  typedef struct packed {
    logic two_wire_data;
    logic two_wire_clk;
    logic tdi;
    logic tck;
    logic tms;
    logic trst;
  } mpg_serial_t;

endpackage : mpg_pkg

//--- core/mpg_gate.sv
// Multi-purpose pin decode, configuration select and output bank gating.
// Assumes pins are level inputs, the serial-mode pin arrives as two comparator flags, and APB at REF_CLK.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps

module mpg_gate (
  input  wire logic                 REF_CLK,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire mpg_pkg::mpg_pins_t   PINS,
  input  wire logic                 LOCK_FAIL_IN,
  input  wire logic                 REF_MISSING_PRI,
  input  wire logic                 REF_MISSING_SEL,
  input  wire logic                 TDO_IN,
  input  wire logic [2:0]           PLL_LOCKED,
  output logic                      MULTI_OUT0,
  output logic                      MULTI_OUT1,
  output mpg_pkg::mpg_serial_t      SERIAL,
  output logic                      PROG_ALLOW,
  output mpg_pkg::mpg_mode_t        MODE,
  output mpg_pkg::mpg_cfg_sel_t     CFG_SEL,
  output logic      [5:0]           DIV_SET_SEL,
  output logic                      REF_SELECT,
  output logic      [5:0]           BANK_TRISTATE,
  output logic      [5:0]           BANK_POWERDOWN,
  output logic      [2:0]           PLL_POWERDOWN,
  output logic      [2:0]           PLL_RELOCK,
  output logic                      OSC_POWERDOWN
);
  import mpg_pkg::*;

  mpg_pins_t    pin_s1_q;
  mpg_pins_t    pin_s2_q;
  logic [1:0]   latch_cnt_q;
  logic         latch_done_q;
  mpg_cfg_sel_t latch_cfg_q;

  logic         manual_freq_select_q;
  logic [5:0]   input_enable_bits_q;
  logic         shutdown_polarity_q;
  logic         pin_role_select_q;
  logic [5:0]   bank_pin_disable_mask_q;
  logic [5:0]   bank_suspend_mask_q;
  logic [2:0]   pll_pause_mask_q;
  logic [11:0]  post_div_set_sel_q;
  logic         primary_source_bit_q;
  logic [11:0]  bank_disable_style_q;
  logic [11:0]  bank_src_q;

  mpg_mode_t    mode_d;
  logic         prog;
  logic [5:0]   eff_in;
  mpg_cfg_sel_t cfg_d;
  logic         pause;
  logic         pin_act;
  logic         glob_off;
  logic         oe_act;
  logic [2:0]   pll_pd_d;
  logic [5:0]   tri_d;
  logic [5:0]   bank_pd_d;
  logic [5:0]   div_d;
  logic         ref_d;
  mpg_serial_t  ser_d;
  logic [2:0]   relock_d;

  logic         setup_ph;
  logic         wr_fire;
  logic [5:0]   idx;

  function automatic logic [1:0] cfg_of(input mpg_cfg_sel_t c, input logic [1:0] p);
    unique case (p)
      2'd0:    cfg_of = c.pll0;
      2'd1:    cfg_of = c.pll1;
      default: cfg_of = c.pll2;
    endcase
  endfunction : cfg_of

  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i == IDX_MODE) || (i == IDX_IN_EN) || (i == IDX_SHUT) || (i == IDX_SUSP) ||
                (i == IDX_PLL_PAUSE) || (i == IDX_DIV_SEL) || (i == IDX_REF_CTL) ||
                (i == IDX_STYLE) || (i == IDX_SRC) || (i == IDX_STATUS);
  endfunction : is_mapped

  // Two-flop synchroniser on every asynchronous pin.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (CE) begin
      pin_s1_q <= PINS;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Power-up capture of inputs zero to four once the synchroniser has filled.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      latch_cnt_q  <= '0;
      latch_done_q <= 1'b0;
      latch_cfg_q  <= '0;
    end else if (CE && !latch_done_q) begin
      if (latch_cnt_q == LATCH_WAIT) begin
        latch_done_q <= 1'b1;
        latch_cfg_q  <= {1'b0, pin_s2_q.in[4:0]};
      end else begin
        latch_cnt_q <= latch_cnt_q + 2'd1;
      end
    end
  end

  assign idx      = PADDR[7:2];
  assign setup_ph = PSEL && !PENABLE;
  assign wr_fire  = CE && PSEL && PENABLE && PREADY && PWRITE && is_mapped(idx);

  // Software register file.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      manual_freq_select_q    <= 1'b0;
      input_enable_bits_q     <= IN_EN_RST;
      shutdown_polarity_q     <= 1'b0;
      pin_role_select_q       <= 1'b0;
      bank_pin_disable_mask_q <= '0;
      bank_suspend_mask_q     <= '0;
      pll_pause_mask_q        <= '0;
      post_div_set_sel_q      <= '0;
      primary_source_bit_q    <= 1'b0;
      bank_disable_style_q    <= '0;
      bank_src_q              <= SRC_RST;
    end else if (wr_fire) begin
      unique case (idx)
        IDX_MODE:      manual_freq_select_q <= PWDATA[0];
        IDX_IN_EN:     input_enable_bits_q <= PWDATA[5:0];
        IDX_SHUT: begin
          shutdown_polarity_q     <= PWDATA[SHUT_POL_BIT];
          pin_role_select_q       <= PWDATA[SHUT_ROLE_BIT];
          bank_pin_disable_mask_q <= PWDATA[SHUT_MASK_LSB +: NUM_BANK];
        end
        IDX_SUSP:      bank_suspend_mask_q <= PWDATA[5:0];
        IDX_PLL_PAUSE: pll_pause_mask_q <= PWDATA[2:0];
        IDX_DIV_SEL:   post_div_set_sel_q <= PWDATA[11:0];
        IDX_REF_CTL:   primary_source_bit_q <= PWDATA[0];
        IDX_STYLE:     bank_disable_style_q <= PWDATA[11:0];
        IDX_SRC:       bank_src_q <= PWDATA[11:0];
        default: begin
        end
      endcase
    end
  end

  // Read data is prepared in the setup cycle so the access cycle completes at once.
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      if (setup_ph) begin
        PREADY  <= 1'b1;
        PSLVERR <= !is_mapped(idx);
        PRDATA  <= '0;
        unique case (idx)
          IDX_MODE:      PRDATA[0] <= manual_freq_select_q;
          IDX_IN_EN:     PRDATA[5:0] <= input_enable_bits_q;
          IDX_SHUT: begin
            PRDATA[SHUT_POL_BIT]                <= shutdown_polarity_q;
            PRDATA[SHUT_ROLE_BIT]               <= pin_role_select_q;
            PRDATA[SHUT_MASK_LSB +: NUM_BANK]   <= bank_pin_disable_mask_q;
          end
          IDX_SUSP:      PRDATA[5:0] <= bank_suspend_mask_q;
          IDX_PLL_PAUSE: PRDATA[2:0] <= pll_pause_mask_q;
          IDX_DIV_SEL:   PRDATA[11:0] <= post_div_set_sel_q;
          IDX_REF_CTL:   PRDATA[0] <= primary_source_bit_q;
          IDX_STYLE:     PRDATA[11:0] <= bank_disable_style_q;
          IDX_SRC:       PRDATA[11:0] <= bank_src_q;
          IDX_STATUS: begin
            PRDATA[5:0]                       <= CFG_SEL;
            PRDATA[STAT_MODE_LSB +: 2]        <= MODE;
            PRDATA[STAT_TRI_LSB +: NUM_BANK]  <= BANK_TRISTATE;
            PRDATA[STAT_PD_LSB +: NUM_PLL]    <= PLL_POWERDOWN;
            PRDATA[STAT_RELCK_LSB +: NUM_PLL] <= PLL_RELOCK;
          end
          default: begin
          end
        endcase
      end else begin
        PREADY  <= 1'b0;
        PSLVERR <= 1'b0;
      end
    end
  end

  // Mode decode, input gating and configuration selection.
  always_comb begin
    pin_act  = pin_s2_q.goe ^ shutdown_polarity_q;
    glob_off = pin_role_select_q && pin_act;
    oe_act   = !pin_role_select_q && pin_act;
    if (glob_off || (!pin_s2_q.ser_hi && !pin_s2_q.ser_lo)) begin
      mode_d = manual_freq_select_q ? MPG_MODE_MAN_ONE : MPG_MODE_MAN_ALL;
    end else if (pin_s2_q.ser_hi) begin
      mode_d = MPG_MODE_TWO_WIRE;
    end else begin
      mode_d = MPG_MODE_JTAG;
    end
    prog   = (mode_d == MPG_MODE_TWO_WIRE) || (mode_d == MPG_MODE_JTAG);
    eff_in = pin_s2_q.in & input_enable_bits_q;
    pause  = 1'b0;
    ref_d  = primary_source_bit_q;
    cfg_d  = latch_cfg_q;
    unique case (mode_d)
      MPG_MODE_MAN_ALL: begin
        if (latch_done_q) begin
          cfg_d = eff_in;
        end
        ref_d = primary_source_bit_q;
      end
      MPG_MODE_MAN_ONE, MPG_MODE_TWO_WIRE, MPG_MODE_JTAG: begin
        cfg_d = latch_cfg_q;
        pause = eff_in[3];
        ref_d = primary_source_bit_q ^ eff_in[5];
      end
    endcase
    ser_d = '0;
    if (prog && !glob_off) begin
      if (mode_d == MPG_MODE_TWO_WIRE) begin
        ser_d.two_wire_data = pin_s2_q.in[0];
        ser_d.two_wire_clk  = pin_s2_q.in[1];
      end else begin
        ser_d.tdi  = pin_s2_q.in[0];
        ser_d.tck  = pin_s2_q.in[1];
        ser_d.tms  = pin_s2_q.in[2];
        ser_d.trst = pin_s2_q.in[4];
      end
    end
  end

  // Bank and PLL gating.
  always_comb begin
    logic [1:0] src;
    logic [1:0] sty;
    logic       pll_off;
    logic       oe_dis;
    src = '0;
    sty = '0;
    pll_off = 1'b0;
    oe_dis = 1'b0;
    pll_pd_d = glob_off ? 3'h0 : ({3{pause}} & pll_pause_mask_q);
    for (int b = 0; b < NUM_BANK; b++) begin
      src     = bank_src_q[2*b +: 2];
      sty     = bank_disable_style_q[2*b +: 2];
      pll_off = (src != SRC_REF) && pll_pd_d[src];
      oe_dis  = oe_act && bank_pin_disable_mask_q[b] && (sty != STYLE_KEEP);
      bank_pd_d[b] = !glob_off && ((pause && bank_suspend_mask_q[b]) || pll_off);
      tri_d[b] = glob_off || oe_dis || bank_pd_d[b] ||
                 ((src != SRC_REF) && PLL_RELOCK[src]);
      div_d[b] = (src != SRC_REF) && post_div_set_sel_q[{src, cfg_of(cfg_d, src)}];
    end
  end

  // A PLL leaving pause must relock; a new pause-end wins over a lock report.
  always_comb begin
    for (int p = 0; p < NUM_PLL; p++) begin
      if (PLL_POWERDOWN[p] && !pll_pd_d[p]) begin
        relock_d[p] = 1'b1;
      end else if (PLL_LOCKED[p] || pll_pd_d[p]) begin
        relock_d[p] = 1'b0;
      end else begin
        relock_d[p] = PLL_RELOCK[p];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      MODE           <= MPG_MODE_MAN_ALL;
      CFG_SEL        <= '0;
      DIV_SET_SEL    <= '0;
      REF_SELECT     <= 1'b0;
      PROG_ALLOW     <= 1'b0;
      SERIAL         <= '0;
      MULTI_OUT0     <= 1'b0;
      MULTI_OUT1     <= 1'b0;
      OSC_POWERDOWN  <= 1'b0;
      BANK_TRISTATE  <= '1;
      BANK_POWERDOWN <= '0;
      PLL_POWERDOWN  <= '0;
      PLL_RELOCK     <= '0;
    end else if (CE) begin
      MODE           <= mode_d;
      CFG_SEL        <= cfg_d;
      DIV_SET_SEL    <= div_d;
      REF_SELECT     <= ref_d;
      PROG_ALLOW     <= prog && !glob_off;
      SERIAL         <= ser_d;
      MULTI_OUT0     <= (mode_d == MPG_MODE_JTAG) ? TDO_IN : LOCK_FAIL_IN;
      MULTI_OUT1     <= (mode_d == MPG_MODE_JTAG) ? REF_MISSING_SEL : REF_MISSING_PRI;
      OSC_POWERDOWN  <= glob_off;
      BANK_TRISTATE  <= tri_d;
      BANK_POWERDOWN <= bank_pd_d;
      PLL_POWERDOWN  <= pll_pd_d;
      PLL_RELOCK     <= relock_d;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_floating_manual: assert property (CE && !pin_s2_q.ser_hi && !pin_s2_q.ser_lo && !manual_freq_select_q
    |=> MODE == MPG_MODE_MAN_ALL) else $error("floating pin did not give all-PLL manual mode");
  a_cfg_live_pins: assert property (CE && mode_d == MPG_MODE_MAN_ALL && latch_done_q
    |=> CFG_SEL.pll1 == ($past(pin_s2_q.in[3:2]) & $past(input_enable_bits_q[3:2])))
    else $error("PLL1 select not taken from its pin pair");
  a_in_disable_low: assert property (CE && mode_d == MPG_MODE_MAN_ALL && latch_done_q && !input_enable_bits_q[0]
    |=> !CFG_SEL.pll0[0]) else $error("disabled input did not read low");
  a_prog_in5_low: assert property (CE && prog && latch_done_q |=> !CFG_SEL.pll2[1])
    else $error("input five not low in programming mode");
  a_ref_primary: assert property (CE && mode_d == MPG_MODE_MAN_ALL
    |=> REF_SELECT == $past(primary_source_bit_q)) else $error("reference not primary in manual mode");
  a_shutdown_off: assert property (CE && pin_role_select_q && (pin_s2_q.goe ^ shutdown_polarity_q)
    |=> BANK_TRISTATE == 6'h3f && OSC_POWERDOWN && !PROG_ALLOW && PLL_POWERDOWN == 3'h0)
    else $error("global shutdown did not gate outputs");
  a_oe_bank_disable: assert property (CE && oe_act && bank_pin_disable_mask_q[0] &&
    bank_disable_style_q[1:0] != STYLE_KEEP |=> BANK_TRISTATE[0]) else $error("output enable missed bank 0");
  a_suspend_disabled: assert property (CE && !input_enable_bits_q[3] && !glob_off
    |=> PLL_POWERDOWN == 3'h0 && BANK_POWERDOWN == 6'h00) else $error("disabled suspend still acted");
  a_suspend_bank: assert property (CE && pause && bank_suspend_mask_q[0] && !glob_off
    |=> BANK_POWERDOWN[0] && BANK_TRISTATE[0]) else $error("suspend did not power down bank 0");
  a_pll_pause_mask: assert property (CE && pause && pll_pause_mask_q[1] && !glob_off
    |=> PLL_POWERDOWN[1]) else $error("pause did not power down PLL 1");
  a_jtag_route: assert property (CE && mode_d == MPG_MODE_JTAG && !glob_off
    |=> SERIAL.tms == $past(pin_s2_q.in[2]) && MULTI_OUT0 == $past(TDO_IN)) else $error("JTAG role routing wrong");
  a_relock_after_pause: assert property (CE && PLL_POWERDOWN[0] && !pll_pd_d[0]
    |=> PLL_RELOCK[0] ##1 (PLL_RELOCK[0] || $past(PLL_LOCKED[0]))) else $error("pause end did not demand relock");

  c_shutdown: cover property (CE && glob_off ##1 OSC_POWERDOWN);
  c_pll_pause: cover property (PLL_POWERDOWN[1] ##[1:20] PLL_RELOCK[1]);
  c_two_wire: cover property (MODE == MPG_MODE_TWO_WIRE && PROG_ALLOW);
  c_jtag: cover property (MODE == MPG_MODE_JTAG && PROG_ALLOW);
  c_oe_disable: cover property (CE && oe_act ##1 BANK_TRISTATE != 6'h00);

endmodule : mpg_gate

//--- verif/mpg_board.sv
// Board-side model for the gating block: PLL lock status and the loss and TDO flags.
// Assumes the bench supplies flag levels and that REF_CLK also clocks the board logic.
`timescale 1ns/1ps

module mpg_board #(
  parameter int RELOCK = 10
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] pll_pd,
  input  wire logic [3:0] flags,
  output logic      [3:0] flags_q,
  output logic      [2:0] locked_q
);
  int cnt_q [3];

  // A powered-down PLL loses lock and needs RELOCK cycles after power returns.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_q  <= 4'h0;
      locked_q <= 3'h7;
      cnt_q    <= '{0, 0, 0};
    end else begin
      flags_q <= flags;
      for (int p = 0; p < 3; p++) begin
        if (pll_pd[p]) begin
          locked_q[p] <= 1'b0;
          cnt_q[p]    <= RELOCK;
        end else if (cnt_q[p] > 0) begin
          cnt_q[p]    <= cnt_q[p] - 1;
          locked_q[p] <= (cnt_q[p] == 1);
        end
      end
    end
  end
endmodule : mpg_board

//--- verif/mpg_gate_bench.sv
// Self-checking bench for the multi-purpose pin decode and output gating block.
// Assumes the board model beside it and a 40 MHz clock; CE drops once to show that it freezes the block.
`timescale 1ns/1ps

module mpg_gate_bench;
  import mpg_pkg::*;

  logic         clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  mpg_pins_t    pins;
  logic [3:0]   flags, flags_q;
  logic [2:0]   locked, pll_pd, relock;
  logic         out0, out1, prog, ref_sel, osc_pd;
  mpg_serial_t  serial;
  mpg_mode_t    mode;
  mpg_cfg_sel_t cfg;
  logic [5:0]   div_sel, tri_b, pd_b;
  int           err_total, checks;

  mpg_gate uut (
    .REF_CLK(clk), .RESET(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PINS(pins), .LOCK_FAIL_IN(flags_q[3]),
    .REF_MISSING_PRI(flags_q[2]), .REF_MISSING_SEL(flags_q[1]), .TDO_IN(flags_q[0]),
    .PLL_LOCKED(locked), .MULTI_OUT0(out0), .MULTI_OUT1(out1), .SERIAL(serial),
    .PROG_ALLOW(prog), .MODE(mode), .CFG_SEL(cfg), .DIV_SET_SEL(div_sel),
    .REF_SELECT(ref_sel), .BANK_TRISTATE(tri_b), .BANK_POWERDOWN(pd_b),
    .PLL_POWERDOWN(pll_pd), .PLL_RELOCK(relock), .OSC_POWERDOWN(osc_pd)
  );

  mpg_board board (
    .clk(clk), .rst(rst), .pll_pd(pll_pd), .flags(flags), .flags_q(flags_q), .locked_q(locked)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic apb(input logic wr_en, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff (pready === 1'b1));
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    settle(3);
  endtask : wr

  task automatic pin(input logic hi, input logic lo, input logic goe, input logic [5:0] v);
    @(posedge clk);
    pins <= '{hi, lo, goe, v};
    settle(5);
  endtask : pin

  task automatic t_power;
    @(posedge clk);
    flags <= 4'ha;
    settle(4);
    apb(1'b0, IDX_IN_EN, 32'h0);
    chk(rd, 32'h3f);
    chk(mode, MPG_MODE_TWO_WIRE);
    chk(cfg, 6'h0d);
    chk({out0, out1}, 2'b10);
    pin(1'b1, 1'b0, 1'b0, 6'h2e);
    chk({serial.two_wire_data, serial.two_wire_clk}, 2'b01);
    chk(cfg, 6'h0d);
    apb(1'b0, 6'h3f, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("t_power done");
  endtask : t_power

  task automatic t_jtag;
    wr(IDX_IN_EN, 32'h0);
    @(posedge clk);
    flags <= 4'h3;
    pin(1'b0, 1'b1, 1'b0, 6'h17);
    chk(mode, MPG_MODE_JTAG);
    chk({serial.tdi, serial.tck, serial.tms, serial.trst}, 4'hf);
    chk({out0, out1}, 2'b11);
    wr(IDX_SUSP, 32'h3f);
    pin(1'b0, 1'b1, 1'b0, 6'h1f);
    chk(pd_b, 6'h00);
    wr(IDX_IN_EN, 32'h3f);
    chk(pd_b, 6'h3f);
    $display("t_jtag done");
  endtask : t_jtag

  task automatic t_pause;
    wr(IDX_SUSP, 32'h05);
    chk({pd_b, tri_b}, 12'h145);
    wr(IDX_SRC, 32'h400);
    wr(IDX_PLL_PAUSE, 32'h2);
    chk({pll_pd, pd_b}, 9'h0a5);
    pin(1'b0, 1'b1, 1'b0, 6'h17);
    chk({pll_pd, relock, tri_b}, 12'h0a0);
    settle(12);
    chk({relock, tri_b}, 9'h000);
    $display("t_pause done");
  endtask : t_pause

  task automatic t_manual;
    pin(1'b0, 1'b0, 1'b0, 6'h1b);
    chk(mode, MPG_MODE_MAN_ALL);
    chk(cfg, 6'h1b);
    wr(IDX_DIV_SEL, 32'h008);
    chk(div_sel, 6'h1f);
    wr(IDX_DIV_SEL, 32'h040);
    chk(div_sel, 6'h20);
    wr(IDX_IN_EN, 32'h3c);
    chk(cfg, 6'h18);
    wr(IDX_IN_EN, 32'h3f);
    pin(1'b0, 1'b0, 1'b0, 6'h24);
    chk(cfg, 6'h24);
    wr(IDX_REF_CTL, 32'h1);
    chk(ref_sel, 1'b1);
    wr(IDX_REF_CTL, 32'h0);
    chk(ref_sel, 1'b0);
    wr(IDX_MODE, 32'h1);
    chk(mode, MPG_MODE_MAN_ONE);
    wr(IDX_MODE, 32'h0);
    chk(mode, MPG_MODE_MAN_ALL);
    $display("t_manual done");
  endtask : t_manual

  task automatic t_gate;
    wr(IDX_STYLE, 32'h008);
    wr(IDX_SHUT, 32'h0300);
    chk(tri_b, 6'h00);
    pin(1'b0, 1'b0, 1'b1, 6'h24);
    chk(tri_b, 6'h01);
    wr(IDX_SHUT, 32'h0301);
    chk(tri_b, 6'h00);
    pin(1'b0, 1'b0, 1'b0, 6'h24);
    wr(IDX_SHUT, 32'h0c01);
    chk(tri_b, 6'h0c);
    wr(IDX_SHUT, 32'h0002);
    pin(1'b1, 1'b0, 1'b1, 6'h24);
    chk({tri_b, osc_pd, prog, pd_b, pll_pd}, 17'h1fc00);
    chk(mode, MPG_MODE_MAN_ALL);
    pin(1'b1, 1'b0, 1'b0, 6'h24);
    chk(mode, MPG_MODE_TWO_WIRE);
    chk({tri_b, osc_pd, prog, relock}, 11'h008);
    $display("t_gate done");
  endtask : t_gate

  // With CE low a pin change must not reach the outputs; it does once CE returns.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    pin(1'b0, 1'b1, 1'b0, 6'h24);
    chk(mode, MPG_MODE_TWO_WIRE);
    @(posedge clk);
    ce <= 1'b1;
    settle(4);
    chk(mode, MPG_MODE_JTAG);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rd, 32'hcd);
    $display("t_freeze done");
  endtask : t_freeze

  task automatic wrap_up;
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst       = 1'b1;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    flags     = 4'h0;
    err_total = 0;
    checks    = 0;
    pins      = '{1'b1, 1'b0, 1'b0, 6'h2d};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_power();
    t_jtag();
    t_pause();
    t_manual();
    t_gate();
    t_freeze();
    wrap_up();
  end

  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    $display("Watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule : mpg_gate_bench
